// [inc/sysclk_defs.svh]
// register map, field positions and reset values of the clock generator
`ifndef SYSCLK_DEFS_SVH
`define SYSCLK_DEFS_SVH

// ***********************************************
// register addresses
// ***********************************************
`define SFR_CLOCK_POWER_ADDR 8'hBE
`define XREG_OSC_TRIM_ADDR 16'h4002
`define XREG_CRYSTAL_CTRL_ADDR 16'h4016

// ***********************************************
// clock and power control field positions
// ***********************************************
`define CP_DOWN_BIT 7
`define CP_RSVD_BIT 6
`define CP_BATT_BIT 5
`define CP_TICKCLR_BIT 4
`define CP_HOLD_BIT 3
`define CP_DIV_MSB 2
`define CP_DIV_LSB 0

// ***********************************************
// crystal control field positions
// ***********************************************
`define XC_ENABLE_BIT 0
`define XC_LOWLOAD_BIT 1
`define XC_TEST_MSB 3
`define XC_TEST_LSB 2

// ***********************************************
// reset values, widths and the battery capture delay
// ***********************************************
`define OSC_TRIM_RESET 8'hFF
`define CRYSTAL_CTRL_RESET 4'h0
`define DIV_CODE_RESET 3'h0
`define DIV_COUNT_W 7
`define GPIO_W 8
`define UNMAPPED_READ 8'h00
`define BATT_CAPTURE_DELAY 2'h3

`endif

// [inc/sysclk_pkg.sv]
// types shared by the clock generator files
package sysclk_pkg;

	// power sequence, gray coded along run, hold, down, wake
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_HOLD = 2'h1,
		PWR_DOWN = 2'h3,
		PWR_WAKE = 2'h2
	} power_state_t;

	typedef enum logic [1:0] {
		BIAS_NONE = 2'h0,
		BIAS_SENSE = 2'h1,
		BIAS_FORCE = 2'h2,
		BIAS_SENSE_FORCE = 2'h3
	} bias_test_t;

endpackage

// [hdl/sysclk_divider.sv]
// power-of-two system clock divider with boundary-only ratio change
`timescale 1ns/1ps
`include "sysclk_defs.svh"

module sysclk_divider (
	input wire logic clk,
	input wire logic srst,
	input wire logic [2:0] divide_code,
	output logic tick,
	output logic [2:0] active_code
);

	logic [`DIV_COUNT_W-1:0] count;
	logic [`DIV_COUNT_W-1:0] next_load;

	// ***********************************************
	// reload value 2^code - 1
	// ***********************************************
	always_comb begin
		next_load = `DIV_COUNT_W'((8'h01 << divide_code) - 8'h01);
	end

	// ***********************************************
	// counter
	// ***********************************************
	// ratio at boundary
	// the new code is only taken when the count has run out, so no
	// period is ever cut short
	always_ff @(posedge clk) begin
		if (srst) begin
			count <= '0;
			active_code <= `DIV_CODE_RESET;
		end else if (count == '0) begin
			count <= next_load;
			active_code <= divide_code;
		end else begin
			count <= count - `DIV_COUNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tick <= 1'b0;
		end else begin
			tick <= (count == '0);
		end
	end

endmodule // sysclk_divider

// [hdl/system_clock_generator.sv]
// system clock generator, power-down control and crystal control registers
`timescale 1ns/1ps
`include "sysclk_defs.svh"

module system_clock_generator (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	input wire logic [15:0] XREG_ADDR,
	input wire logic XREG_WR,
	input wire logic XREG_RD,
	input wire logic [7:0] XREG_WDATA,
	output logic [7:0] XREG_RDATA,
	input wire logic [7:0] GPIO_IN,
	input wire logic BATTERY_INSERT,
	input wire logic CRYSTAL_CLOCK_GOOD,
	input wire logic CRYSTAL_CLOCK,
	output logic SYSCLK_TICK,
	output logic [2:0] SYSCLK_ACTIVE_CODE,
	output logic [7:0] OSC_TRIM_CODE,
	output logic POWER_DOWN,
	output logic WAKE_POR,
	output logic RTC_TICK_CLEAR,
	output logic GPIO_HOLD,
	output logic [7:0] GPIO_VALUE,
	output logic BUTTON_EVENT,
	output logic CRYSTAL_ENABLE,
	output logic CRYSTAL_LOW_LOAD,
	output logic [1:0] CRYSTAL_BIAS_TEST,
	output logic CRYSTAL_GOOD_STATUS,
	output logic FC_CRYSTAL_CLOCK
);

	sysclk_pkg::power_state_t state;
	sysclk_pkg::power_state_t next_state;
	logic [2:0] sysclk_divide_code;
	logic power_down_request;
	logic port_hold;
	logic battery_insert_flag;
	logic [7:0] osc_trim_code;
	logic crystal_enable;
	logic crystal_low_load_sel;
	sysclk_pkg::bias_test_t crystal_bias_test_sel;
	logic sfr_hit;
	logic trim_hit;
	logic crystal_hit;
	logic [7:0] gpio_meta;
	logic [7:0] gpio_sync;
	logic [7:0] gpio_prev;
	logic [7:0] gpio_fall;
	logic any_fall;
	logic deferred_event;
	logic batt_meta;
	logic batt_sync;
	logic [1:0] batt_wait;
	logic batt_captured;
	logic good_meta;
	logic good_sync;
	logic [7:0] frozen_gpio;

	assign sfr_hit = (SFR_ADDR == `SFR_CLOCK_POWER_ADDR);
	assign trim_hit = (XREG_ADDR == `XREG_OSC_TRIM_ADDR);
	assign crystal_hit = (XREG_ADDR == `XREG_CRYSTAL_CTRL_ADDR);

	// ***********************************************
	// system clock divider
	// ***********************************************
	// oscillator feeds divider
	// CLK stands for the oscillator output here; the divider tick leaves on
	// SYSCLK_TICK as an enable, while every register here runs on each CLK edge
	sysclk_divider u_divider (
		.clk(CLK),
		.srst(SRST),
		.divide_code(sysclk_divide_code),
		.tick(SYSCLK_TICK),
		.active_code(SYSCLK_ACTIVE_CODE)
	);

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	always_ff @(posedge CLK) begin
		if (SRST) begin
			gpio_meta <= 8'hFF;
			gpio_sync <= 8'hFF;
			gpio_prev <= 8'hFF;
			batt_meta <= 1'b0;
			batt_sync <= 1'b0;
			good_meta <= 1'b0;
			good_sync <= 1'b0;
		end else begin
			gpio_meta <= GPIO_IN;
			gpio_sync <= gpio_meta;
			gpio_prev <= gpio_sync;
			batt_meta <= BATTERY_INSERT;
			batt_sync <= batt_meta;
			good_meta <= CRYSTAL_CLOCK_GOOD;
			good_sync <= good_meta;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `GPIO_W; g = g + 1) begin : g_fall
			assign gpio_fall[g] = gpio_prev[g] & ~gpio_sync[g];
		end
	endgenerate

	assign any_fall = |gpio_fall;

	// ***********************************************
	// clock and power control register
	// ***********************************************
	// divide code field
	always_ff @(posedge CLK) begin
		if (SRST) begin
			sysclk_divide_code <= `DIV_CODE_RESET;
		end else if (SFR_WR && sfr_hit) begin
			sysclk_divide_code <= SFR_WDATA[`CP_DIV_MSB:`CP_DIV_LSB];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			RTC_TICK_CLEAR <= 1'b0;
		end else begin
			RTC_TICK_CLEAR <= SFR_WR && sfr_hit && SFR_WDATA[`CP_TICKCLR_BIT];
		end
	end

	// shutdown request bit
	// a wake clears it, standing in for the power-on reset that follows
	always_ff @(posedge CLK) begin
		if (SRST) begin
			power_down_request <= 1'b0;
		end else if (state == sysclk_pkg::PWR_WAKE) begin
			power_down_request <= 1'b0;
		end else if (SFR_WR && sfr_hit) begin
			power_down_request <= SFR_WDATA[`CP_DOWN_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			port_hold <= 1'b0;
		end else if (state == sysclk_pkg::PWR_WAKE) begin
			port_hold <= 1'b0;
		end else if (SFR_WR && sfr_hit) begin
			port_hold <= SFR_WDATA[`CP_HOLD_BIT];
		end
	end

	// battery flag capture
	// caught once, a few cycles after reset release, never by the reset
	always_ff @(posedge CLK) begin
		if (SRST) begin
			batt_wait <= 2'h0;
			batt_captured <= 1'b0;
			battery_insert_flag <= 1'b0;
		end else if (!batt_captured) begin
			if (batt_wait == `BATT_CAPTURE_DELAY) begin
				battery_insert_flag <= batt_sync;
				batt_captured <= 1'b1;
			end else begin
				batt_wait <= batt_wait + 2'h1;
			end
		end
	end

	// ***********************************************
	// power sequence
	// ***********************************************
	// wake on edge only
	// hold expected before shutdown
	// a shutdown without hold is still honoured, but presses just before it
	// are then not deferred
	always_comb begin
		next_state = state;
		case (state)
			sysclk_pkg::PWR_RUN: begin
				if (power_down_request) begin
					next_state = sysclk_pkg::PWR_DOWN;
				end else if (port_hold) begin
					next_state = sysclk_pkg::PWR_HOLD;
				end
			end
			sysclk_pkg::PWR_HOLD: begin
				if (power_down_request) begin
					next_state = sysclk_pkg::PWR_DOWN;
				end else if (!port_hold) begin
					next_state = sysclk_pkg::PWR_RUN;
				end
			end
			sysclk_pkg::PWR_DOWN: begin
				if (any_fall || deferred_event) begin
					next_state = sysclk_pkg::PWR_WAKE;
				end
			end
			sysclk_pkg::PWR_WAKE: begin
				next_state = sysclk_pkg::PWR_RUN;
			end
			default: begin
				next_state = sysclk_pkg::PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= sysclk_pkg::PWR_RUN;
		end else begin
			state <= next_state;
		end
	end

	// defer presses during hold
	// a press in the same cycle the hold ends still counts: set wins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			deferred_event <= 1'b0;
		end else if ((port_hold || state == sysclk_pkg::PWR_HOLD) && any_fall) begin
			deferred_event <= 1'b1;
		end else if (state == sysclk_pkg::PWR_WAKE) begin
			deferred_event <= 1'b0;
		end else if (state == sysclk_pkg::PWR_RUN) begin
			deferred_event <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			frozen_gpio <= 8'hFF;
		end else if (!port_hold && state != sysclk_pkg::PWR_DOWN) begin
			frozen_gpio <= gpio_sync;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			POWER_DOWN <= 1'b0;
			WAKE_POR <= 1'b0;
			BUTTON_EVENT <= 1'b0;
		end else begin
			POWER_DOWN <= (next_state == sysclk_pkg::PWR_DOWN);
			WAKE_POR <= (next_state == sysclk_pkg::PWR_WAKE);
			BUTTON_EVENT <= any_fall && !port_hold && (state == sysclk_pkg::PWR_RUN);
		end
	end

	assign GPIO_HOLD = port_hold;
	assign GPIO_VALUE = frozen_gpio;

	// ***********************************************
	// extended registers
	// ***********************************************
	// trim code register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			osc_trim_code <= `OSC_TRIM_RESET;
		end else if (XREG_WR && trim_hit) begin
			osc_trim_code <= XREG_WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			{crystal_low_load_sel, crystal_enable} <= 2'(`CRYSTAL_CTRL_RESET);
			crystal_bias_test_sel <= sysclk_pkg::bias_test_t'(2'(`CRYSTAL_CTRL_RESET >> 2));
		end else if (XREG_WR && crystal_hit) begin
			crystal_enable <= XREG_WDATA[`XC_ENABLE_BIT];
			crystal_low_load_sel <= XREG_WDATA[`XC_LOWLOAD_BIT];
			crystal_bias_test_sel <= sysclk_pkg::bias_test_t'(
				XREG_WDATA[`XC_TEST_MSB:`XC_TEST_LSB]);
		end
	end

	assign OSC_TRIM_CODE = osc_trim_code;
	assign CRYSTAL_ENABLE = crystal_enable;
	assign CRYSTAL_LOW_LOAD = crystal_low_load_sel;
	assign CRYSTAL_BIAS_TEST = crystal_bias_test_sel;
	assign CRYSTAL_GOOD_STATUS = good_sync;
	// crystal to counter
	// the enable is static software state, so gating cannot chop a cycle
	// except at the moment software turns the crystal on or off
	assign FC_CRYSTAL_CLOCK = CRYSTAL_CLOCK & crystal_enable;

	// ***********************************************
	// read paths
	// ***********************************************
	// reserved reads zero
	always_ff @(posedge CLK) begin
		if (SRST) begin
			SFR_RDATA <= `UNMAPPED_READ;
		end else if (SFR_RD) begin
			if (sfr_hit) begin
				SFR_RDATA <= {power_down_request, 1'b0, battery_insert_flag,
					1'b0, port_hold, sysclk_divide_code};
			end else begin
				SFR_RDATA <= `UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			XREG_RDATA <= `UNMAPPED_READ;
		end else if (XREG_RD) begin
			if (trim_hit) begin
				XREG_RDATA <= osc_trim_code;
			end else if (crystal_hit) begin
				XREG_RDATA <= {4'h0, crystal_bias_test_sel,
					crystal_low_load_sel, crystal_enable};
			end else begin
				XREG_RDATA <= `UNMAPPED_READ;
			end
		end
	end

endmodule // system_clock_generator

// [bench/system_clock_generator_props.sv]
// assertions on the clock generator ports
`timescale 1ns/1ps
`include "sysclk_defs.svh"

module system_clock_generator_props (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	input wire logic [7:0] SFR_RDATA,
	input wire logic [15:0] XREG_ADDR,
	input wire logic XREG_RD,
	input wire logic [7:0] XREG_RDATA,
	input wire logic CRYSTAL_CLOCK,
	input wire logic CRYSTAL_ENABLE,
	input wire logic FC_CRYSTAL_CLOCK,
	input wire logic SYSCLK_TICK,
	input wire logic [2:0] SYSCLK_ACTIVE_CODE,
	input wire logic POWER_DOWN,
	input wire logic WAKE_POR,
	input wire logic RTC_TICK_CLEAR,
	input wire logic GPIO_HOLD,
	input wire logic [7:0] GPIO_VALUE,
	input wire logic BUTTON_EVENT
);
	// *****
	// properties
	// *****
	logic be_wr;
	logic be_rd;
	logic xc_rd;
	assign be_wr = SFR_WR && SFR_ADDR == `SFR_CLOCK_POWER_ADDR;
	assign be_rd = SFR_RD && SFR_ADDR == `SFR_CLOCK_POWER_ADDR;
	assign xc_rd = XREG_RD && XREG_ADDR == `XREG_CRYSTAL_CTRL_ADDR;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_tick_clear_pulse: assert property (
		be_wr && SFR_WDATA[4] |=> RTC_TICK_CLEAR)
		else $error("tick clear pulse missing");
	a_tick_clear_quiet: assert property (
		!(be_wr && SFR_WDATA[4]) |=> !RTC_TICK_CLEAR)
		else $error("tick clear without write");
	a_hold_bit_write: assert property (
		be_wr |=> $past(WAKE_POR) || GPIO_HOLD == $past(SFR_WDATA[3]))
		else $error("hold bit not taken");
	a_reserved_reads_zero: assert property (
		be_rd |=> !SFR_RDATA[6] && !SFR_RDATA[4])
		else $error("reserved bit not zero");
	a_crystal_upper_zero: assert property (
		xc_rd |=> XREG_RDATA[7:4] == 4'h0)
		else $error("crystal upper bits not zero");
	a_counter_clock_gate: assert property (
		FC_CRYSTAL_CLOCK == (CRYSTAL_CLOCK && CRYSTAL_ENABLE))
		else $error("counter clock gate wrong");
	a_gpio_stays_frozen: assert property (
		GPIO_HOLD && $past(GPIO_HOLD) |-> $stable(GPIO_VALUE))
		else $error("gpio moved under hold");
	a_press_deferred: assert property (
		GPIO_HOLD && $past(GPIO_HOLD) |-> !BUTTON_EVENT)
		else $error("button event under hold");
	a_tick_every_four: assert property (
		SYSCLK_TICK && SYSCLK_ACTIVE_CODE == 3'h2
		|=> !SYSCLK_TICK [*3] ##1 SYSCLK_TICK)
		else $error("tick spacing wrong");
	a_shutdown_powers_down: assert property (
		be_wr && SFR_WDATA[7] && !WAKE_POR |-> ##[1:3] POWER_DOWN)
		else $error("shutdown not reached");
	a_wake_ends_down: assert property (
		WAKE_POR |-> !POWER_DOWN ##1 !WAKE_POR)
		else $error("wake pulse wrong");
endmodule // system_clock_generator_props

bind system_clock_generator system_clock_generator_props
	system_clock_generator_props_i (.CLK, .SRST, .SFR_ADDR, .SFR_WR,
	.SFR_RD, .SFR_WDATA, .SFR_RDATA, .XREG_ADDR, .XREG_RD, .XREG_RDATA,
	.CRYSTAL_CLOCK, .CRYSTAL_ENABLE, .FC_CRYSTAL_CLOCK, .SYSCLK_TICK,
	.SYSCLK_ACTIVE_CODE, .POWER_DOWN, .WAKE_POR, .RTC_TICK_CLEAR,
	.GPIO_HOLD, .GPIO_VALUE, .BUTTON_EVENT);

// [bench/system_clock_generator_tb_top.sv]
// self-checking bench for the clock generator
`timescale 1ns/1ps
`include "sysclk_defs.svh"

module system_clock_generator_tb_top;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic [7:0] SFR_ADDR = 8'h00;
	logic SFR_WR = 1'b0;
	logic SFR_RD = 1'b0;
	logic [7:0] SFR_WDATA = 8'h00;
	logic [15:0] XREG_ADDR = 16'h0000;
	logic XREG_WR = 1'b0;
	logic XREG_RD = 1'b0;
	logic [7:0] XREG_WDATA = 8'h00;
	logic [7:0] GPIO_IN = 8'hFF;
	logic BATTERY_INSERT = 1'b1;
	logic CRYSTAL_CLOCK_GOOD = 1'b0;
	logic CRYSTAL_CLOCK = 1'b0;
	logic [7:0] SFR_RDATA, XREG_RDATA, OSC_TRIM_CODE, GPIO_VALUE;
	logic SYSCLK_TICK, POWER_DOWN, WAKE_POR, RTC_TICK_CLEAR, GPIO_HOLD;
	logic BUTTON_EVENT, CRYSTAL_ENABLE, CRYSTAL_LOW_LOAD;
	logic CRYSTAL_GOOD_STATUS, FC_CRYSTAL_CLOCK;
	logic [2:0] SYSCLK_ACTIVE_CODE;
	logic [1:0] CRYSTAL_BIAS_TEST;
	localparam logic [15:0] be_a = {8'h00, `SFR_CLOCK_POWER_ADDR};
	localparam logic [15:0] trim_a = `XREG_OSC_TRIM_ADDR;
	localparam logic [15:0] xc_a = `XREG_CRYSTAL_CTRL_ADDR;
	int bad_count = 0;
	int compares = 0;
	int ticks_cleared = 0;
	int presses = 0;
	int n;
	int i;
	logic [7:0] q;
	logic [7:0] d;

	system_clock_generator system_clock_generator_i (.CLK, .SRST,
		.SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .XREG_ADDR,
		.XREG_WR, .XREG_RD, .XREG_WDATA, .XREG_RDATA, .GPIO_IN,
		.BATTERY_INSERT, .CRYSTAL_CLOCK_GOOD, .CRYSTAL_CLOCK, .SYSCLK_TICK,
		.SYSCLK_ACTIVE_CODE, .OSC_TRIM_CODE, .POWER_DOWN, .WAKE_POR,
		.RTC_TICK_CLEAR, .GPIO_HOLD, .GPIO_VALUE, .BUTTON_EVENT,
		.CRYSTAL_ENABLE, .CRYSTAL_LOW_LOAD, .CRYSTAL_BIAS_TEST,
		.CRYSTAL_GOOD_STATUS, .FC_CRYSTAL_CLOCK);

	always #25 CLK = ~CLK;
	always @(posedge CLK) CRYSTAL_CLOCK <= ~CRYSTAL_CLOCK;
	// tick clear and button pulses are counted, not caught by polling
	always @(posedge CLK) begin
		if (RTC_TICK_CLEAR === 1'b1) begin
			ticks_cleared++;
		end
		if (BUTTON_EVENT === 1'b1) begin
			presses++;
		end
	end

	// *****
	// tasks
	// *****
	function automatic logic [7:0] cp_exp(input logic [7:0] v);
		return {v[7], 1'b0, BATTERY_INSERT, 1'b0, v[3:0]};
	endfunction
	function automatic logic sel(input int k);
		if (k == 3) return SYSCLK_ACTIVE_CODE === i[2:0];
		return k == 0 ? POWER_DOWN : k == 1 ? WAKE_POR : SYSCLK_TICK;
	endfunction
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// register access, read data taken a cycle after the strobe
	task automatic acc(input bit x, input bit w, input logic [15:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge CLK);
		#1;
		XREG_ADDR = a;
		XREG_WDATA = wd;
		SFR_ADDR = a[7:0];
		SFR_WDATA = wd;
		{XREG_WR, XREG_RD} = x ? {w, !w} : 2'h0;
		{SFR_WR, SFR_RD} = x ? 2'h0 : {w, !w};
		@(posedge CLK);
		#1;
		{XREG_WR, XREG_RD, SFR_WR, SFR_RD} = 4'h0;
		@(posedge CLK);
		#1;
		rd = x ? XREG_RDATA : SFR_RDATA;
	endtask
	task automatic wait_hi(input int k);
		for (n = 0; n < 400 && sel(k) !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		if (n == 400) begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// *****
	// tests
	// *****
	initial begin
		void'($urandom(32'hC81B));
		repeat (4) @(posedge CLK);
		#1;
		SRST = 1'b0;
		repeat (6) @(posedge CLK);
		acc(1, 0, trim_a, 8'h00, q);
		chk("trim reset", `OSC_TRIM_RESET, q);
		acc(1, 0, xc_a, 8'h00, q);
		chk("crystal reset", 8'h00, q);
		acc(0, 0, be_a, 8'h00, q);
		chk("control reset", cp_exp(8'h00), q);
		acc(1, 0, 16'h4003, 8'h00, q);
		chk("unmapped read", `UNMAPPED_READ, q);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			CRYSTAL_CLOCK_GOOD = i[0];
			d = i == 0 ? 8'h00 : 8'($urandom);
			acc(1, 1, trim_a, d, q);
			acc(1, 0, trim_a, 8'h00, q);
			chk("trim", d, q);
			chk("trim pins", d, OSC_TRIM_CODE);
			d = 8'($urandom);
			d[3:2] = i[1:0];
			acc(1, 1, xc_a, d, q);
			acc(1, 0, xc_a, 8'h00, q);
			chk("crystal", {4'h0, d[3:0]}, q);
			q = {4'h0, CRYSTAL_BIAS_TEST, CRYSTAL_LOW_LOAD, CRYSTAL_ENABLE};
			chk("crystal pins", {4'h0, d[3:0]}, q);
			q = {7'h0, FC_CRYSTAL_CLOCK};
			chk("counter clock", {7'h0, CRYSTAL_CLOCK & d[0]}, q);
			chk("clock good", {7'h0, i[0]}, {7'h0, CRYSTAL_GOOD_STATUS});
		end
		$display("test crystal done");
		for (i = 0; i < 8; i++) begin
			acc(0, 1, be_a, {5'h00, i[2:0]}, q);
			wait_hi(3);
			wait_hi(2);
			n = 0;
			do begin
				@(posedge CLK);
				#1;
				n++;
			end while (SYSCLK_TICK !== 1'b1 && n < 300);
			if (SYSCLK_TICK !== 1'b1) begin
				bad_count++;
				wrap_up();
			end
			chk("tick period", 8'(1 << i), 8'(n));
		end
		$display("test divider done");
		acc(0, 1, be_a, 8'h50, q);
		acc(0, 0, be_a, 8'h00, q);
		chk("tick clear read", cp_exp(8'h00), q);
		chk("tick clear pulses", 8'h01, 8'(ticks_cleared));
		$display("test tick clear done");
		GPIO_IN = 8'h0F;
		repeat (5) @(posedge CLK);
		#1;
		chk("gpio sample", 8'h0F, GPIO_VALUE);
		chk("press seen", 8'h01, 8'(presses));
		// hold goes up before the shutdown request
		acc(0, 1, be_a, 8'h08, q);
		chk("hold pin", 8'h01, {7'h0, GPIO_HOLD});
		GPIO_IN = 8'hFF;
		repeat (5) @(posedge CLK);
		#1;
		chk("gpio frozen", 8'h0F, GPIO_VALUE);
		acc(0, 1, be_a, 8'h88, q);
		wait_hi(0);
		GPIO_IN = 8'hFE;
		wait_hi(1);
		chk("down at wake", 8'h00, {7'h0, POWER_DOWN});
		GPIO_IN = 8'hFF;
		acc(0, 0, be_a, 8'h00, q);
		chk("bits after wake", cp_exp(8'h00), q);
		// a press under hold is deferred and wakes at once
		acc(0, 1, be_a, 8'h08, q);
		GPIO_IN = 8'hFD;
		repeat (5) @(posedge CLK);
		#1;
		acc(0, 1, be_a, 8'h88, q);
		wait_hi(0);
		wait_hi(1);
		chk("deferred press", 8'h01, 8'(presses));
		GPIO_IN = 8'hFF;
		$display("test shutdown done");
		wrap_up();
	end
endmodule // system_clock_generator_tb_top
